/* File: verilog/postdiv_map.vh */
`ifndef POSTDIV_MAP_VH
`define POSTDIV_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses (most significant byte first)
// ----------------------------------------------------------------------
`define PD_ADDR_B_HI      8'hA7
`define PD_ADDR_B_MID     8'hA8
`define PD_ADDR_B_LO      8'hA9
`define PD_ADDR_C_HI      8'hAA
`define PD_ADDR_C_MID     8'hAB
`define PD_ADDR_C_LO      8'hAC

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PD_CFG_RST        24'h000000
`define PD_BYTE_RST       8'h00
`define PD_MASK_RST       3'h0
`define PD_MASK_FULL      3'h7
`define PD_UNMAPPED_DATA  8'h00

// ----------------------------------------------------------------------
// Field layout of a configuration word
// ----------------------------------------------------------------------
`define PD_SHAPE_MSB      23
`define PD_SHAPE_LSB      20
`define PD_FRAME_CODE     4'hF
`define PD_STYLE_BIT      19
`define PD_POL_BIT        18
`define PD_SEL_MSB        17
`define PD_SEL_LSB        16
`define PD_INTV_MSB       15
`define PD_INTV_LSB       0

// ----------------------------------------------------------------------
// Related clock selector codes
// ----------------------------------------------------------------------
`define PD_SEL_A          2'h0
`define PD_SEL_B          2'h1
`define PD_SEL_C          2'h2
`define PD_SEL_D          2'h3

`endif

/* File: verilog/postdiv_channel.v */
`timescale 1ns/1ps
`include "postdiv_map.vh"

module postdiv_channel (
	input  wire        clk_i,     // VCO clock
	input  wire        sys_rst_i, // Synchronous reset, active high
	input  wire        ce_i,      // Clock enable
	input  wire        load_i,    // Apply cfg_i this cycle
	input  wire [23:0] cfg_i,     // Complete configuration word
	input  wire        rel_ok_i,  // Selected related clock is legal
	input  wire        rel_i,     // Selected related clock level
	output wire        out_o,     // Divided clock or frame pulse
	output wire        frame_o    // Frame-pulse mode active
);

	reg  [23:0] cfg_q;
	reg  [23:0] div_cnt_q;
	reg  [23:0] div_cnt_d;
	reg         div_out_q;
	reg         rel_prev_q;
	reg  [15:0] per_cnt_q;
	reg         pulse_q;
	reg         out_q;
	wire        frame_mode;
	wire [23:0] eff_ratio;
	wire [23:0] hi_len;
	wire [15:0] intv;
	wire [15:0] intv_m1;
	wire        rel_rise;
	wire        rel_fall;
	wire        boundary;

	assign frame_mode = (cfg_q[`PD_SHAPE_MSB:`PD_SHAPE_LSB] == `PD_FRAME_CODE); // [RULE1]
	// A ratio of one cannot be made from a single-edge counter, so it runs as two.
	assign eff_ratio  = (cfg_q == 24'h000001) ? 24'h000002 : cfg_q;             // [RULE2]
	assign hi_len     = eff_ratio - {1'b0, eff_ratio[23:1]};
	assign intv       = cfg_q[`PD_INTV_MSB:`PD_INTV_LSB];
	assign intv_m1    = intv - 16'h0001;
	assign rel_rise   = rel_i & ~rel_prev_q;
	assign rel_fall   = ~rel_i & rel_prev_q;
	assign boundary   = (intv != 16'h0000) && (per_cnt_q == intv_m1);

	always @* begin
		if (div_cnt_q >= eff_ratio - 24'h000001) begin
			div_cnt_d = 24'h000000;
		end else begin
			div_cnt_d = div_cnt_q + 24'h000001;
		end
	end

	// ----------------------------------------------------------------------
	// Regular clock divider and frame pulse engine
	// ----------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_q      <= `PD_CFG_RST;
			div_cnt_q  <= 24'h000000;
			div_out_q  <= 1'b0;
			rel_prev_q <= 1'b0;
			per_cnt_q  <= 16'h0000;
			pulse_q    <= 1'b0;
			out_q      <= 1'b0;
		end else if (ce_i) begin
			rel_prev_q <= rel_i;
			if (load_i) begin
				cfg_q     <= cfg_i;
				div_cnt_q <= 24'h000000;
				div_out_q <= 1'b0;
				per_cnt_q <= 16'h0000;
				pulse_q   <= 1'b0;
			end else if (!frame_mode) begin
				// A zero ratio parks the output low.
				if (cfg_q == 24'h000000) begin
					div_cnt_q <= 24'h000000;
					div_out_q <= 1'b0;
				end else begin
					div_cnt_q <= div_cnt_d;                                 // [RULE4]
					div_out_q <= (div_cnt_d < hi_len);                      // [RULE2]
				end
			end else if (!rel_ok_i || intv == 16'h0000) begin
				per_cnt_q <= 16'h0000;
				pulse_q   <= 1'b0;
			end else begin
				if (rel_rise) begin
					per_cnt_q <= boundary ? 16'h0000 : per_cnt_q + 16'h0001; // [RULE5]
				end
				if (cfg_q[`PD_STYLE_BIT]) begin
					// Edge style: pulse opens on the boundary rising edge.
					if (rel_rise) begin
						pulse_q <= boundary;                                // [RULE10] [RULE7]
					end
				end else if (rel_fall) begin
					// Centred style: open half a period before the boundary.
					pulse_q <= boundary;                                    // [RULE10] [RULE7]
				end
			end
			out_q <= frame_mode ? (pulse_q ^ cfg_q[`PD_POL_BIT]) : div_out_q; // [RULE9]
		end
	end

	assign out_o   = out_q;
	assign frame_o = frame_mode;

endmodule // postdiv_channel

/* File: verilog/synth_postdiv_frame_pulse.v */
// Operation
// RULE1: A shape field of all ones turns the output into a frame pulse described by bits 19:0.
// RULE2: Any other shape value gives a 50% duty clock whose ratio is the whole 24-bit word; the code keeps odd ratios high one cycle longer.
// RULE3: Software keeps regular-clock ratios at or below 15728639 so they never alias frame mode.
// RULE4: In clock mode the output is the VCO clock divided by the programmed ratio; the code divides by 2 for ratio 1 and parks low for 0.
// RULE5: In frame mode pulses are spaced by the 16-bit interval count of related-clock periods.
// RULE6: A two-bit selector picks the related sibling clock; for output C code 10 is reserved.
// RULE7: Each frame pulse lasts exactly one period of the related clock.
// RULE8: Software never lets a frame-pulse output select its own divider as related clock.
// RULE9: The polarity bit gives a plain pulse when 0 and an inverted pulse when 1.
// RULE10: The style bit centres the frame boundary in the pulse when 0 and puts it on an edge when 1.
// RULE11: Each configuration word is readable, writable and resets to zero, which means clock mode.
// RULE12: A new word takes effect only once all three of its bytes have been written.
`timescale 1ns/1ps
`include "postdiv_map.vh"

module synth_postdiv_frame_pulse (
	input  wire       clk_i,         // VCO clock, 40 MHz
	input  wire       sys_rst_i,     // Synchronous reset, active high
	input  wire       ce_i,          // Clock enable, freezes all state when low
	input  wire [7:0] addr_i,        // Register byte address
	input  wire       wr_en_i,       // Byte write strobe
	input  wire       rd_en_i,       // Byte read strobe
	input  wire [7:0] wdata_i,       // Write data
	output wire [7:0] rdata_o,       // Read data, valid the cycle after rd_en_i
	input  wire       rel_a_i,       // Sibling output A level
	input  wire       rel_d_i,       // Sibling output D level
	output wire       out_b_o,       // Output B clock or frame pulse
	output wire       out_c_o,       // Output C clock or frame pulse
	output wire       frame_b_o,     // Output B in frame-pulse mode
	output wire       frame_c_o,     // Output C in frame-pulse mode
	output wire       pending_b_o,   // Output B word partly written
	output wire       pending_c_o    // Output C word partly written
);

	// ----------------------------------------------------------------------
	// Staged bytes and write tracking
	// ----------------------------------------------------------------------
	reg  [23:0] stage_b_q;
	reg  [23:0] stage_c_q;
	reg  [2:0]  mask_b_q;
	reg  [2:0]  mask_c_q;
	reg  [2:0]  mask_b_d;
	reg  [2:0]  mask_c_d;
	reg  [7:0]  rdata_q;
	reg  [7:0]  rdata_d;
	reg         load_b_q;
	reg         load_c_q;
	reg         rel_b_sel;
	reg         rel_b_ok;
	reg         rel_c_sel;
	reg         rel_c_ok;
	wire [2:0]  hit_b;
	wire [2:0]  hit_c;
	wire        wr;
	wire        out_b;
	wire        out_c;

	// ----------------------------------------------------------------------
	// Byte address decode
	// ----------------------------------------------------------------------
	assign wr = wr_en_i & ce_i;

	// Index 2 is the high byte, index 0 the low byte.
	assign hit_b = {addr_i == `PD_ADDR_B_HI,
		addr_i == `PD_ADDR_B_MID,
		addr_i == `PD_ADDR_B_LO};
	assign hit_c = {addr_i == `PD_ADDR_C_HI,
		addr_i == `PD_ADDR_C_MID,
		addr_i == `PD_ADDR_C_LO};

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			stage_b_q <= `PD_CFG_RST;                                          // [RULE11]
			stage_c_q <= `PD_CFG_RST;                                          // [RULE11]
		end else if (wr) begin
			if (hit_b[2]) begin
				stage_b_q[23:16] <= wdata_i;
			end
			if (hit_b[1]) begin
				stage_b_q[15:8] <= wdata_i;
			end
			if (hit_b[0]) begin
				stage_b_q[7:0] <= wdata_i;
			end
			if (hit_c[2]) begin
				stage_c_q[23:16] <= wdata_i;
			end
			if (hit_c[1]) begin
				stage_c_q[15:8] <= wdata_i;
			end
			if (hit_c[0]) begin
				stage_c_q[7:0] <= wdata_i;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Byte mask and apply strobe
	// ----------------------------------------------------------------------
	// The byte mask accumulates in any order; a ratio is never applied while
	// some of its bytes still hold the old value.
	always @* begin
		mask_b_d = mask_b_q | (wr ? hit_b : `PD_MASK_RST);                     // [RULE12]
		mask_c_d = mask_c_q | (wr ? hit_c : `PD_MASK_RST);                     // [RULE12]
	end

	// The apply strobe lasts one cycle and empties the mask with it, so the
	// write that completes a word is never counted towards the next one.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			mask_b_q <= `PD_MASK_RST;
			mask_c_q <= `PD_MASK_RST;
			load_b_q <= 1'h0;
			load_c_q <= 1'h0;
		end else if (ce_i) begin
			load_b_q <= (mask_b_d == `PD_MASK_FULL);                           // [RULE12]
			load_c_q <= (mask_c_d == `PD_MASK_FULL);                           // [RULE12]
			mask_b_q <= (mask_b_d == `PD_MASK_FULL) ? `PD_MASK_RST : mask_b_d;
			mask_c_q <= (mask_c_d == `PD_MASK_FULL) ? `PD_MASK_RST : mask_c_d;
		end
	end

	// ----------------------------------------------------------------------
	// Read back
	// ----------------------------------------------------------------------
	// Reads return the staged word so software sees what it wrote even while
	// the remaining bytes are still outstanding.
	always @* begin
		case (addr_i)
			`PD_ADDR_B_HI:  rdata_d = stage_b_q[23:16];                        // [RULE11]
			`PD_ADDR_B_MID: rdata_d = stage_b_q[15:8];
			`PD_ADDR_B_LO:  rdata_d = stage_b_q[7:0];
			`PD_ADDR_C_HI:  rdata_d = stage_c_q[23:16];                        // [RULE11]
			`PD_ADDR_C_MID: rdata_d = stage_c_q[15:8];
			`PD_ADDR_C_LO:  rdata_d = stage_c_q[7:0];
			default:        rdata_d = `PD_UNMAPPED_DATA;
		endcase
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= `PD_BYTE_RST;
		end else if (ce_i && rd_en_i) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------------
	// Related clock selection
	// ----------------------------------------------------------------------
	// The selector is captured on the same apply strobe as the channel's word,
	// so the related clock and the frame decision always switch together; a
	// reserved code parks the pulse rather than looping an output back on itself.
	reg [1:0] sel_b_q;
	reg [1:0] sel_c_q;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			sel_b_q <= `PD_SEL_A;
			sel_c_q <= `PD_SEL_A;
		end else if (ce_i) begin
			if (load_b_q) begin
				sel_b_q <= stage_b_q[`PD_SEL_MSB:`PD_SEL_LSB];
			end
			if (load_c_q) begin
				sel_c_q <= stage_c_q[`PD_SEL_MSB:`PD_SEL_LSB];
			end
		end
	end

	always @* begin
		rel_b_sel = 1'b0;
		rel_b_ok  = 1'b1;
		case (sel_b_q)                                                         // [RULE6]
			`PD_SEL_A: rel_b_sel = rel_a_i;
			`PD_SEL_C: rel_b_sel = out_c;
			`PD_SEL_D: rel_b_sel = rel_d_i;
			default:   rel_b_ok  = 1'b0;                                       // [RULE8]
		endcase
	end

	always @* begin
		rel_c_sel = 1'b0;
		rel_c_ok  = 1'b1;
		case (sel_c_q)                                                         // [RULE6]
			`PD_SEL_A: rel_c_sel = rel_a_i;
			`PD_SEL_B: rel_c_sel = out_b;
			`PD_SEL_D: rel_c_sel = rel_d_i;
			default:   rel_c_ok  = 1'b0;                                       // [RULE8]
		endcase
	end

	// ----------------------------------------------------------------------
	// Output channels
	// ----------------------------------------------------------------------
	postdiv_channel u_chan_b (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.load_i    (load_b_q),
		.cfg_i     (stage_b_q),
		.rel_ok_i  (rel_b_ok),
		.rel_i     (rel_b_sel),
		.out_o     (out_b),
		.frame_o   (frame_b_o)
	);

	postdiv_channel u_chan_c (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.load_i    (load_c_q),
		.cfg_i     (stage_c_q),
		.rel_ok_i  (rel_c_ok),
		.rel_i     (rel_c_sel),
		.out_o     (out_c),
		.frame_o   (frame_c_o)
	);

	assign out_b_o     = out_b;
	assign out_c_o     = out_c;
	assign rdata_o     = rdata_q;
	assign pending_b_o = (mask_b_q != `PD_MASK_RST);
	assign pending_c_o = (mask_c_q != `PD_MASK_RST);

endmodule // synth_postdiv_frame_pulse

/* File: verif/synth_postdiv_frame_pulse_properties.sv */
`timescale 1ns/1ps
module synth_postdiv_frame_pulse_properties (
	input wire logic       clk_i,       // Clock
	input wire logic       sys_rst_i,   // Reset
	input wire logic       ce_i,        // Enable
	input wire logic [7:0] addr_i,      // Address
	input wire logic       wr_en_i,     // Write
	input wire logic       rd_en_i,     // Read
	input wire logic [7:0] wdata_i,     // Write data
	input wire logic [7:0] rdata_o,     // Read data
	input wire logic       out_b_o,     // Output B
	input wire logic       out_c_o,     // Output C
	input wire logic       frame_b_o,   // B framing
	input wire logic       frame_c_o,   // C framing
	input wire logic       pending_b_o, // B staged
	input wire logic       pending_c_o  // C staged
);
	// ---
	// Register port and apply timing
	// ---
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	wire um = addr_i < 8'hA7 || addr_i > 8'hAC;
	wire wb = ce_i && wr_en_i && addr_i >= 8'hA7 && addr_i <= 8'hA9;
	wire wc = ce_i && wr_en_i && !um && !wb;
	sequence s_wr; ce_i && wr_en_i && !rd_en_i && !um; endsequence
	sequence s_rd; ce_i && rd_en_i && !wr_en_i && addr_i == $past(addr_i); endsequence
	chk_wr_rd_echo:
		assert property (s_wr ##1 s_rd |=> rdata_o == $past(wdata_i, 2))
		else $error("staged byte not read back");
	chk_reset_clear:
		assert property ($fell(sys_rst_i) |-> !frame_b_o && !frame_c_o && rdata_o == 8'h00)
		else $error("state not cleared by reset");
	chk_unmapped_rd:
		assert property (ce_i && rd_en_i && um |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_hold:
		assert property (!(ce_i && rd_en_i) |=> $stable(rdata_o))
		else $error("read data moved without a read");
	chk_ce_freeze:
		assert property (!ce_i |=> $stable({out_b_o, out_c_o, pending_c_o}))
		else $error("outputs moved while disabled");
	chk_apply_b:
		assert property (!$stable(frame_b_o) |-> $past(wb, 2))
		else $error("B mode changed without a B write");
	chk_apply_c:
		assert property (!$stable(frame_c_o) |-> $past(wc, 2))
		else $error("C mode changed without a C write");
	chk_pend_rise:
		assert property ($rose(pending_b_o) || $rose(pending_c_o) |-> $past(wb || wc))
		else $error("pending rose without a write");
endmodule // synth_postdiv_frame_pulse_properties

bind synth_postdiv_frame_pulse synth_postdiv_frame_pulse_properties chk_u (
	.clk_i, .sys_rst_i, .ce_i, .addr_i, .wr_en_i, .rd_en_i, .wdata_i, .rdata_o,
	.out_b_o, .out_c_o, .frame_b_o, .frame_c_o, .pending_b_o, .pending_c_o);

/* File: verif/sibling_clk_model.sv */
`timescale 1ns/1ps
// ---
// Sibling outputs A and D
// ---
// Free-running, so the frame logic always has related edges to count.
module sibling_clk_model #(
	parameter int DIV_A = 4,
	parameter int DIV_D = 6
) (
	input  wire logic clk_i,     // VCO clock
	input  wire logic sys_rst_i, // Reset
	output wire logic rel_a_o,   // Sibling A
	output wire logic rel_d_o    // Sibling D
);
	int ca_q = 0;
	int cd_q = 0;
	always @(posedge clk_i) begin
		ca_q <= (sys_rst_i || ca_q == DIV_A - 1) ? 0 : ca_q + 1;
		cd_q <= (sys_rst_i || cd_q == DIV_D - 1) ? 0 : cd_q + 1;
	end
	assign rel_a_o = ca_q < DIV_A / 2;
	assign rel_d_o = cd_q < DIV_D / 2;
endmodule // sibling_clk_model

/* File: verif/synth_postdiv_frame_pulse_tb_top.sv */
`timescale 1ns/1ps
module synth_postdiv_frame_pulse_tb_top;
	// ---
	// Stimulus and checking
	// ---
	logic        clk_i = 1'h0, sys_rst_i = 1'h1, ce_i = 1'h1, rd_q = 1'h0;
	logic        wr_en_i = 1'h0, rd_en_i = 1'h0;
	logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, lf = 8'h20;
	logic [23:0] cyc = 24'h0, got, w, sp, st, st1, exp_q[$];
	logic [23:0] rt[3] = '{24'h4, 24'h5, 24'h3};
	logic [23:0] fw[3] = '{24'hF90004, 24'hFB0004, 24'hF80004};
	logic [23:0] fp[3] = '{24'h2, 24'h6, 24'h4};
	string       nm_q[$];
	int          miscompares = 0, n_compared = 0;
	event        res_ev;
	wire  [7:0]  rdata_o;
	wire         rel_a, rel_d, out_b_o, out_c_o, frame_b_o, frame_c_o, pending_b_o, pending_c_o;

	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 24'h1;

	synth_postdiv_frame_pulse dut_u (.clk_i, .sys_rst_i, .ce_i, .addr_i, .wr_en_i, .rd_en_i,
		.wdata_i, .rdata_o, .rel_a_i(rel_a), .rel_d_i(rel_d), .out_b_o, .out_c_o, .frame_b_o,
		.frame_c_o, .pending_b_o, .pending_c_o);
	sibling_clk_model sib_u (.clk_i, .sys_rst_i, .rel_a_o(rel_a), .rel_d_o(rel_d));

	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmp(input logic [23:0] g);
		logic [23:0] e;
		string n;
		e = exp_q.pop_front();
		n = nm_q.pop_front();
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s: expected %0h seen %0h", n, e, g);
		end
	endtask
	// Reads are judged here, one cycle after the read was taken.
	always @(posedge clk_i) begin
		if (rd_q)
			cmp({16'h0000, rdata_o});
		rd_q <= ce_i && rd_en_i && !sys_rst_i;
	end
	always @(res_ev) cmp(got);
	task automatic note(input string n, input logic [23:0] e);
		exp_q.push_back(e);
		nm_q.push_back(n);
	endtask
	task automatic post(input string n, input logic [23:0] e, g);
		note(n, e);
		got = g;
		->res_ev;
		#0;
	endtask
	task automatic bus(input logic wr, rd, input logic [7:0] a, d);
		@(posedge clk_i);
		wr_en_i <= wr;
		rd_en_i <= rd;
		addr_i <= a;
		wdata_i <= d;
	endtask
	task automatic rd(input logic [7:0] a, e);
		note("rdata", {16'h0000, e});
		bus(1'h0, 1'h1, a, 8'h00);
	endtask
	task automatic tick;
		@(posedge clk_i);
		#1;
	endtask
	task automatic edge_to(input logic ch, l, output logic [23:0] t);
		int n;
		for (n = 0; n < 300 && (ch ? out_c_o : out_b_o) === l; n++) tick;
		for (n = 0; n < 300 && (ch ? out_c_o : out_b_o) !== l; n++) tick;
		t = cyc;
	endtask
	// The first pulse after an apply may be short, so the second one is timed.
	task automatic measure(input logic ch, l);
		edge_to(ch, l, st);
		edge_to(ch, l, st);
		edge_to(ch, !l, w);
		edge_to(ch, l, sp);
		w = w - st;
		sp = sp - st;
	endtask
	task automatic cfg(input logic ch, input logic [23:0] v);
		bus(1'h1, 1'h0, ch ? 8'hAA : 8'hA7, v[23:16]);
		bus(1'h1, 1'h0, ch ? 8'hAB : 8'hA8, v[15:8]);
		bus(1'h1, 1'h0, ch ? 8'hAC : 8'hA9, v[7:0]);
		bus(1'h0, 1'h0, 8'h00, 8'h00);
		repeat (4) tick;
	endtask
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		for (int a = 166; a < 174; a++)
			rd(8'(a), 8'h00);
		for (int a = 166; a < 174; a++) begin
			lf = nx(lf);
			bus(1'h1, 1'h0, 8'(a), lf);
			rd(8'(a), (a < 167 || a > 172) ? 8'h00 : lf);
		end
		bus(1'h0, 1'h0, 8'h00, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			cfg(i == 2, rt[i]);
			measure(i == 2, 1'h1);
			post("high time", (rt[i] + 24'h1) >> 1, w);
			post("period", rt[i], sp);
		end
		@(posedge clk_i) ce_i <= 1'h0;
		repeat (5) @(posedge clk_i);
		ce_i <= 1'h1;
		bus(1'h1, 1'h0, 8'hA7, 8'hF8);
		bus(1'h1, 1'h0, 8'hAB, 8'hFF);
		bus(1'h0, 1'h0, 8'h00, 8'h00);
		repeat (4) tick;
		post("pending b", 24'h1, {23'h0, pending_b_o});
		post("pending c", 24'h1, {23'h0, pending_c_o});
		post("frame b", 24'h0, {23'h0, frame_b_o});
		cfg(1'h0, 24'hF80004);
		post("frame b", 24'h1, {23'h0, frame_b_o});
		post("pending b", 24'h0, {23'h0, pending_b_o});
		cfg(1'h0, 24'h000002);
		cfg(1'h1, 24'hEFFFFF);
		post("frame c", 24'h0, {23'h0, frame_c_o});
		post("pending c", 24'h0, {23'h0, pending_c_o});
		$display("test clock mode done");
		for (int i = 0; i < 3; i++) begin
			cfg(1'h1, fw[i]);
			post("frame c", 24'h1, {23'h0, frame_c_o});
			measure(1'h1, 1'h1);
			post("pulse width", fp[i], w);
			post("pulse spacing", fp[i] * 24'h4, sp);
		end
		st1 = st;
		cfg(1'h1, 24'hF00004);
		measure(1'h1, 1'h1);
		post("style offset", 24'h2, (st1 - st) & 24'h3);
		cfg(1'h1, 24'hFC0004);
		measure(1'h1, 1'h0);
		post("inverted width", 24'h4, w);
		cfg(1'h1, 24'hFA0004);
		w = 24'h0;
		repeat (60) begin
			tick;
			w = w + {23'h0, out_c_o !== 1'h0};
		end
		post("parked highs", 24'h0, w);
		cfg(1'h1, 24'h000003);
		cfg(1'h0, 24'hFA0004);
		measure(1'h0, 1'h1);
		post("b pulse width", 24'h3, w);
		post("b pulse spacing", 24'hC, sp);
		$display("test frame mode done");
		summarize;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		summarize;
	end
endmodule // synth_postdiv_frame_pulse_tb_top
